//--- hdl/nsi_defs.vh
// Purpose: Constants for the NAND pin-level signal interface
// Assumes: System clock 50 MHz; link pins sampled by clk_sys_in
// Notes:   Included by the signal interface modules
//
// Contract
// - One shared 8-bit DQ bus, time-multiplexed
// - CLE write cycle captures command byte
// - ALE write cycle captures address byte
// - Async: each WE# strobe writes one byte
// - Async: each RE# strobe presents next byte
// - NV-DDR: WE# is clock, RE# direction
// - W/R# level picks who drives DQ/DQS
// - DDR data timed by sender-driven DQS
// - Optional complementary DQS in DDR2/DDR3
// - Optional complementary RE in DDR2/DDR3
// - Async/DDR2/DDR3 latch cmd/addr on WE#
// - Write protect blocks program and erase
// - R/B# open-drain low while array busy
// - Deselected target ignores all bus cycles
// - Each die runs and reports independently
// - ENo drives next device's ENi
// - ENi from previous ENo, first unconnected
`ifndef NSI_DEFS_VH
`define NSI_DEFS_VH

`define NSI_DQ_W        8
`define NSI_NUM_LUN     2
`define NSI_MODE_W      2
`define NSI_MODE_ASYNC  2'h0
`define NSI_MODE_DDR    2'h1
`define NSI_MODE_DDR2   2'h2
`define NSI_MODE_DDR3   2'h3
`define NSI_BYTE_RST    8'h00
`define NSI_PROG_CMD    8'h10
`define NSI_ERASE_CMD   8'hD0

`endif

//--- hdl/nsi_sync.v
// Purpose: Two-flop synchroniser for one pin level
// Assumes: Input is asynchronous to clk_sys_in
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module nsi_sync #(
  parameter RST_VAL = 1'b0
) (
  // System
  input  wire clk_sys_in,
  input  wire resetn_in,
  // Level
  input  wire d_in,
  output wire q_out
);
  reg meta_r;
  reg sync_r;

  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule // nsi_sync

//--- hdl/nsi_signal_if.v
// Purpose: Device-side pin logic of a NAND target
// Assumes: Pins sampled by clk_sys_in; array core outside
// Notes:   Edges on WE#/CLK, RE#, DQS found by sampling
`timescale 1ns/10ps
`include "nsi_defs.vh"
module nsi_signal_if (
  // System
  input  wire                      clk_sys_in,
  input  wire                      resetn_in,
  // Mode and core options
  input  wire [`NSI_MODE_W-1:0]    mode_sel_in,
  input  wire                      dqs_diff_en_in,
  input  wire                      re_diff_en_in,
  // Control pins
  input  wire                      ce_n_in,
  input  wire                      cle_in,
  input  wire                      ale_in,
  input  wire                      we_n_in,
  input  wire                      re_n_in,
  input  wire                      re_c_in,
  input  wire                      wp_n_in,
  // DQ pins
  input  wire [`NSI_DQ_W-1:0]      dq_in,
  output reg  [`NSI_DQ_W-1:0]      dq_out,
  output wire                      dq_oe_n_out,
  // DQS pins
  input  wire                      dqs_in,
  output reg                       dqs_out,
  output wire                      dqs_oe_n_out,
  input  wire                      dqs_c_in,
  output wire                      dqs_c_out,
  output wire                      dqs_c_oe_n_out,
  // Ready/busy pin
  output wire                      rb_n_out,
  output wire                      rb_n_oe_n_out,
  // Enumeration chain
  input  wire                      en_chain_in,
  output reg                       en_chain_out,
  // Core side
  output reg  [`NSI_DQ_W-1:0]      cmd_byte_out,
  output reg                       cmd_valid_out,
  output reg  [`NSI_DQ_W-1:0]      addr_byte_out,
  output reg                       addr_valid_out,
  output reg  [`NSI_DQ_W-1:0]      wdata_byte_out,
  output reg                       wdata_valid_out,
  output reg                       prog_erase_ok_out,
  output reg                       prog_erase_refused_out,
  output wire                      rdata_req_out,
  input  wire [`NSI_DQ_W-1:0]      rdata_byte_in,
  input  wire [`NSI_NUM_LUN-1:0]   lun_busy_in,
  input  wire [`NSI_NUM_LUN-1:0]   lun_sel_in,
  output reg  [`NSI_NUM_LUN-1:0]   lun_status_out,
  input  wire                      en_pass_in
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam NPIN = 8 + `NSI_DQ_W;
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s;
  assign pin_raw = {dq_in, dqs_c_in, re_c_in, dqs_in, wp_n_in,
                    re_n_in, we_n_in, ale_in, cle_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      nsi_sync #(.RST_VAL(1'b1)) u_sync (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .d_in       (pin_raw[gi]),
        .q_out      (pin_s[gi])
      );
    end
  endgenerate

  wire ce_s;
  wire en_s;
  nsi_sync #(.RST_VAL(1'b1)) u_sync_ce (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .d_in       (ce_n_in),
    .q_out      (ce_s)
  );
  nsi_sync #(.RST_VAL(1'b0)) u_sync_en (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .d_in       (en_chain_in),
    .q_out      (en_s)
  );

  wire                 cle_s   = pin_s[0];
  wire                 ale_s   = pin_s[1];
  wire                 we_s    = pin_s[2];
  wire                 re_s    = pin_s[3];
  wire                 wp_s    = pin_s[4];
  wire                 dqs_s   = pin_s[5];
  wire                 rec_s   = pin_s[6];
  wire                 dqsc_s  = pin_s[7];
  wire [`NSI_DQ_W-1:0] dq_s    = pin_s[NPIN-1:8];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  reg we_d_r;
  reg re_d_r;
  reg dqs_d_r;
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      we_d_r  <= 1'b1;
      re_d_r  <= 1'b1;
      dqs_d_r <= 1'b1;
    end else begin
      we_d_r  <= we_s;
      re_d_r  <= re_s;
      dqs_d_r <= dqs_s;
    end
  end

  wire sel      = ~ce_s;
  wire is_async = (mode_sel_in == `NSI_MODE_ASYNC);
  wire is_ddr1  = (mode_sel_in == `NSI_MODE_DDR);
  wire is_ddr23 = ~is_async & ~is_ddr1;
  // WE# or CLK rising edge; in NV-DDR the pin is the clock
  wire we_rise  = we_s & ~we_d_r;
  wire re_fall  = ~re_s & re_d_r;
  // Differential strobe options need the complement to agree
  wire dqs_ok   = ~(dqs_diff_en_in & is_ddr23) | (dqs_s ^ dqsc_s);
  wire re_ok    = ~(re_diff_en_in & is_ddr23) | (re_s ^ rec_s);
  wire dqs_edge = (dqs_s ^ dqs_d_r) & dqs_ok;
  // NV-DDR: W/R# high means host drives
  wire host_wr  = re_s;
  // Mixed CLE+ALE is not expected; command wins if it happens
  wire ca_cycle = sel & we_rise & (cle_s | ale_s);
  wire wd_async = sel & is_async & we_rise & ~cle_s & ~ale_s;
  wire wd_ddr   = sel & ~is_async & host_wr & ~cle_s & ~ale_s & dqs_edge;
  wire rd_async = sel & is_async & re_fall;
  wire rd_ddr   = sel & ~is_async & ~host_wr & ~cle_s & ~ale_s & we_rise & re_ok;
  assign rdata_req_out = rd_async | rd_ddr;

  // ----------------------------------------------------------------
  // Capture of command, address and data
  // ----------------------------------------------------------------
  wire pe_cmd = (dq_s == `NSI_PROG_CMD) | (dq_s == `NSI_ERASE_CMD);
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_byte_out           <= `NSI_BYTE_RST;
      cmd_valid_out          <= 1'b0;
      addr_byte_out          <= `NSI_BYTE_RST;
      addr_valid_out         <= 1'b0;
      wdata_byte_out         <= `NSI_BYTE_RST;
      wdata_valid_out        <= 1'b0;
      prog_erase_ok_out      <= 1'b0;
      prog_erase_refused_out <= 1'b0;
    end else begin
      cmd_valid_out          <= ca_cycle & cle_s;
      addr_valid_out         <= ca_cycle & ~cle_s & ale_s;
      wdata_valid_out        <= wd_async | wd_ddr;
      prog_erase_ok_out      <= ca_cycle & cle_s & pe_cmd & wp_s;
      prog_erase_refused_out <= ca_cycle & cle_s & pe_cmd & ~wp_s;
      if (ca_cycle & cle_s)
        cmd_byte_out <= dq_s;
      if (ca_cycle & ~cle_s & ale_s)
        addr_byte_out <= dq_s;
      if (wd_async | wd_ddr)
        wdata_byte_out <= dq_s;
    end
  end

  // ----------------------------------------------------------------
  // Read path and DQ/DQS drive
  // ----------------------------------------------------------------
  reg rd_drive_r;
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_drive_r <= 1'b0;
      dq_out     <= `NSI_BYTE_RST;
      dqs_out    <= 1'b0;
    end else begin
      // Async read: drive while RE# low; DDR: while W/R# low
      rd_drive_r <= sel & (is_async ? ~re_s : ~host_wr);
      if (rdata_req_out)
        dq_out <= rdata_byte_in;
      if (rd_ddr)
        dqs_out <= ~dqs_out;
      else if (~sel | host_wr | is_async)
        dqs_out <= 1'b0;
    end
  end

  assign dq_oe_n_out    = ~rd_drive_r;
  assign dqs_oe_n_out   = ~(rd_drive_r & ~is_async);
  assign dqs_c_out      = ~dqs_out;
  assign dqs_c_oe_n_out = ~(rd_drive_r & is_ddr23 & dqs_diff_en_in);

  // ----------------------------------------------------------------
  // Per-die status, ready/busy, enumeration
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lun_status_out <= {`NSI_NUM_LUN{1'b0}};
      en_chain_out   <= 1'b0;
    end else begin
      lun_status_out <= lun_busy_in & lun_sel_in;
      en_chain_out   <= en_s & en_pass_in;
    end
  end

  // Open drain: only ever drives low
  assign rb_n_out      = 1'b0;
  assign rb_n_oe_n_out = ~(|lun_busy_in);
endmodule // nsi_signal_if

//--- testbench/nsi_host_model.sv
// Purpose: Host controller model driving the NAND pins
// Assumes: Strobes run at the 160 ns link rate, eight system clocks
// Notes:   DQ released between cycles shows the inverse of the last byte
`timescale 1ns/10ps
module nsi_host_model (
  // Clock
  input  wire       clk_sys_in,
  // Pins
  output reg        ce_n_out,
  output reg        cle_out,
  output reg        ale_out,
  output reg        we_n_out,
  output reg        re_n_out,
  output reg  [7:0] dq_out,
  output reg        dq_en_out
);
  initial begin
    ce_n_out  = 1'b1;
    cle_out   = 1'b0;
    ale_out   = 1'b0;
    we_n_out  = 1'b1;
    re_n_out  = 1'b1;
    dq_out    = 8'h00;
    dq_en_out = 1'b0;
  end
  // Half link period
  task automatic half;
    repeat (4) @(negedge clk_sys_in);
  endtask
  // One byte, held across the rising strobe edge
  task automatic wr(input logic ce, input logic c, input logic a, input logic [7:0] d);
    @(negedge clk_sys_in);
    ce_n_out  = ce;
    cle_out   = c & ~a;
    ale_out   = a;
    dq_out    = d;
    dq_en_out = 1'b1;
    we_n_out  = 1'b0;
    half;
    we_n_out  = 1'b1;
    half;
    cle_out   = 1'b0;
    ale_out   = 1'b0;
    dq_en_out = 1'b0;
    ce_n_out  = 1'b1;
  endtask
  // One read strobe; also W/R# low in DDR modes
  task automatic rd;
    @(negedge clk_sys_in);
    ce_n_out = 1'b0;
    re_n_out = 1'b0;
    half;
    re_n_out = 1'b1;
    half;
    ce_n_out = 1'b1;
  endtask
endmodule // nsi_host_model

//--- testbench/nsi_signal_if_chk.sv
// Purpose: Port assertions for the NAND signal interface
// Assumes: Core inputs held low during reset
// Notes:   Bound to every instance of the interface
`timescale 1ns/10ps
`include "nsi_defs.vh"
module nsi_signal_if_chk (
  input wire                    clk_sys_in,
  input wire                    resetn_in,
  input wire [`NSI_MODE_W-1:0]  mode_sel_in,
  input wire                    ce_n_in,
  input wire [`NSI_DQ_W-1:0]    dq_out,
  input wire                    dqs_out,
  input wire                    dqs_oe_n_out,
  input wire                    dqs_c_out,
  input wire                    rb_n_out,
  input wire                    rb_n_oe_n_out,
  input wire                    en_chain_out,
  input wire [`NSI_DQ_W-1:0]    cmd_byte_out,
  input wire                    cmd_valid_out,
  input wire                    addr_valid_out,
  input wire                    wdata_valid_out,
  input wire                    prog_erase_ok_out,
  input wire                    prog_erase_refused_out,
  input wire                    rdata_req_out,
  input wire [`NSI_DQ_W-1:0]    rdata_byte_in,
  input wire [`NSI_NUM_LUN-1:0] lun_busy_in,
  input wire [`NSI_NUM_LUN-1:0] lun_sel_in,
  input wire [`NSI_NUM_LUN-1:0] lun_status_out,
  input wire                    en_pass_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // Six cycles covers the synchroniser delay
  sequence s_ce_idle; ce_n_in [*6]; endsequence
  sequence s_pe_flag; prog_erase_ok_out || prog_erase_refused_out; endsequence
  a_ce_ignore: assert property (s_ce_idle |-> !(cmd_valid_out || addr_valid_out || wdata_valid_out))
    else $error("Byte taken while deselected");
  a_pe_cmd: assert property (s_pe_flag |-> cmd_valid_out && !(prog_erase_ok_out && prog_erase_refused_out) && (cmd_byte_out == `NSI_PROG_CMD || cmd_byte_out == `NSI_ERASE_CMD))
    else $error("Write-protect flag without confirm command");
  a_cmd_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("Command pulse longer than one cycle");
  a_cmd_addr_excl: assert property (!(cmd_valid_out && addr_valid_out))
    else $error("Command and address taken together");
  a_read_data: assert property (rdata_req_out |=> !rdata_req_out && dq_out == $past(rdata_byte_in))
    else $error("Read byte not presented");
  a_rb_busy: assert property (rb_n_out == 1'b0 && rb_n_oe_n_out == !(|lun_busy_in))
    else $error("Ready/busy wrong");
  a_die_status: assert property ($past(resetn_in) |-> lun_status_out == $past(lun_busy_in & lun_sel_in))
    else $error("Die status wrong");
  a_dqs_dir: assert property (!dqs_oe_n_out |-> mode_sel_in != `NSI_MODE_ASYNC)
    else $error("Strobe driven in async mode");
  a_dqs_comp: assert property (dqs_c_out == ~dqs_out)
    else $error("Strobe complement wrong");
  a_enum_gate: assert property (en_chain_out |-> $past(en_pass_in))
    else $error("Enumerate output without pass");
endmodule // nsi_signal_if_chk
bind nsi_signal_if nsi_signal_if_chk nsi_signal_if_chk_inst (.clk_sys_in, .resetn_in, .mode_sel_in,
  .ce_n_in, .dq_out, .dqs_out, .dqs_oe_n_out, .dqs_c_out, .rb_n_out, .rb_n_oe_n_out, .en_chain_out,
  .cmd_byte_out, .cmd_valid_out, .addr_valid_out, .wdata_valid_out, .prog_erase_ok_out,
  .prog_erase_refused_out, .rdata_req_out, .rdata_byte_in, .lun_busy_in, .lun_sel_in,
  .lun_status_out, .en_pass_in);

//--- testbench/nsi_signal_if_tb.sv
// Purpose: Self-checking bench for the NAND signal interface
// Assumes: Host model drives pins at the falling clock edge
// Notes:   Differential strobe inputs stay idle, so those checks are limited
`timescale 1ns/10ps
`include "nsi_defs.vh"
module nsi_signal_if_tb;
  reg        clk_sys_in = 1'b0, resetn_in = 1'b0, dqs_diff_en_in = 1'b0, re_diff_en_in = 1'b0;
  reg        wp_n_in = 1'b1, dqs_in = 1'b1, dqs_c_in = 1'b0, re_c_in = 1'b0;
  reg        en_chain_in = 1'b0, en_pass_in = 1'b0;
  reg  [1:0] mode_sel_in = `NSI_MODE_ASYNC, lun_busy_in = 2'h0, lun_sel_in = 2'h0;
  reg  [7:0] rdata_byte_in = 8'h00;
  reg  [6:0] flg = 7'h00;
  int        n_errors = 0, check_count = 0;
  wire       ce_n_in, cle_in, ale_in, we_n_in, re_n_in, dq_en, dq_oe_n_out, dqs_out, dqs_oe_n_out;
  wire       dqs_c_out, dqs_c_oe_n_out, rb_n_out, rb_n_oe_n_out, en_chain_out, cmd_valid_out;
  wire       addr_valid_out, wdata_valid_out, prog_erase_ok_out, prog_erase_refused_out;
  wire       rdata_req_out;
  wire [1:0] lun_status_out;
  wire [7:0] dq_h, dq_out, cmd_byte_out, addr_byte_out, wdata_byte_out;
  wire [7:0] dq_in = !dq_oe_n_out ? dq_out : (dq_en ? dq_h : ~dq_h);
  // Rows: {ce_n, cle, ale, wp_n}, byte, {cmd, addr, data, ok, refused}
  logic [16:0] rows [6] = '{{4'b0101, 8'h00, 5'b10000}, {4'b0011, 8'h5A, 5'b01000},
    {4'b0001, 8'hA5, 5'b00100}, {4'b0101, 8'h10, 5'b10010}, {4'b0100, 8'hD0, 5'b10001},
    {4'b1101, 8'h10, 5'b00000}};
  always #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
    flg <= flg | {cmd_valid_out, addr_valid_out, wdata_valid_out, prog_erase_ok_out,
                  prog_erase_refused_out, !dqs_oe_n_out, !dqs_c_oe_n_out};
  nsi_host_model nsi_host_model_inst (.clk_sys_in, .ce_n_out(ce_n_in), .cle_out(cle_in),
    .ale_out(ale_in), .we_n_out(we_n_in), .re_n_out(re_n_in), .dq_out(dq_h), .dq_en_out(dq_en));
  nsi_signal_if nsi_signal_if_inst (.clk_sys_in, .resetn_in, .mode_sel_in, .dqs_diff_en_in,
    .re_diff_en_in, .ce_n_in, .cle_in, .ale_in, .we_n_in, .re_n_in, .re_c_in, .wp_n_in, .dq_in,
    .dq_out, .dq_oe_n_out, .dqs_in, .dqs_out, .dqs_oe_n_out, .dqs_c_in, .dqs_c_out,
    .dqs_c_oe_n_out, .rb_n_out, .rb_n_oe_n_out, .en_chain_in, .en_chain_out, .cmd_byte_out,
    .cmd_valid_out, .addr_byte_out, .addr_valid_out, .wdata_byte_out, .wdata_valid_out,
    .prog_erase_ok_out, .prog_erase_refused_out, .rdata_req_out, .rdata_byte_in, .lun_busy_in,
    .lun_sel_in, .lun_status_out, .en_pass_in);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    chk({dq_oe_n_out, dqs_oe_n_out, rb_n_oe_n_out, cmd_valid_out}, 8'h0E);
    foreach (rows[i]) begin
      wp_n_in = rows[i][13];
      flg = 7'h00;
      nsi_host_model_inst.wr(rows[i][16], rows[i][15], rows[i][14], rows[i][12:5]);
      repeat (4) @(negedge clk_sys_in);
      chk(flg[6:2], rows[i][4:0]);
      if (|rows[i][4:2])
        chk(rows[i][4] ? cmd_byte_out : rows[i][3] ? addr_byte_out : wdata_byte_out,
            rows[i][12:5]);
    end
    // Back-to-back reads with new core data each time
    for (int k = 0; k < 2; k++) begin
      rdata_byte_in = k ? 8'h3C : 8'hC3;
      nsi_host_model_inst.rd;
      chk(dq_out, rdata_byte_in);
    end
    chk(flg[1:0], 8'h00);
    lun_busy_in = 2'h2;
    lun_sel_in  = 2'h3;
    repeat (2) @(negedge clk_sys_in);
    chk({rb_n_oe_n_out, rb_n_out, lun_status_out}, 8'h02);
    lun_busy_in = 2'h0;
    en_chain_in = 1'b1;
    en_pass_in  = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    chk({rb_n_oe_n_out, lun_status_out, en_chain_out}, 8'h09);
    en_pass_in = 1'b0;
    mode_sel_in = `NSI_MODE_DDR2;
    dqs_diff_en_in = 1'b1;
    flg = 7'h00;
    nsi_host_model_inst.rd;
    chk({flg[1:0], en_chain_out}, 8'h06);
    chk({dqs_out, dqs_c_out}, 8'h01);
    complete_run;
  end
endmodule // nsi_signal_if_tb
